// ---- src/clock_startup_calibration.sv ----
// start-up delay sequencer and oscillator trim register
// assumes one 50 MHz clock; supply detect and wake come from pins
// Operation
// - with the RC oscillator wake takes 6 cycles and reset adds 14 cycles, +4.1 ms or +65 ms.
// - with the 128 kHz oscillator wake takes 6 cycles and reset adds 14 cycles, +4 ms or +64 ms.
// - with reset pin disabled, code 00 reset delay grows to 14 cycles plus 4.1 ms.
// - the start-up select resets to code 10, the slowly rising power option.
// - every chip reset loads the factory trim value into the trim register.
// - software may write the trim register at any time and the oscillator follows it.
// - trim bit 7 picks the low or high overlapping range.
// - trim bits 6 to 0 tune upward monotonically within the range.
// - clock source code 0011 selects the 128 kHz low-power oscillator.
// - the supply detector crossing starts the delay count and reset holds until it ends.
`timescale 1ns/1ps
`default_nettype none
`include "clock_startup_consts.svh"
module clock_startup_calibration (
  input  wire logic       clock,        // block clock, 50 MHz
  input  wire logic       rst,          // async reset, high
  input  wire logic [3:0] regAddr,      // register address
  input  wire logic [7:0] regWdata,     // write data
  input  wire logic       regWrite,     // write strobe
  input  wire logic       regRead,      // read strobe
  output logic      [7:0] regRdata,     // read data, cycle after strobe
  input  wire logic       supplyOk,     // supply detector, above threshold
  input  wire logic       wakeReq,      // wake from power-down/save
  output logic            coreHold,     // core held in reset/sleep
  output logic      [7:0] trimValue,    // trim to the RC oscillator
  output logic            rangeSelectBit, // oscillator range, 1 = high
  output logic      [6:0] fineTuneBits,   // tune within range
  output logic            lowPowerClk   // 128 kHz source selected
);

  // -----------------------------------------------------------------
  // input synchronisers
  // -----------------------------------------------------------------
  logic supplySync;
  logic wakeSync;
  logic wakeSeen_reg;

  sync_two uSyncSupply (
    .clock (clock),
    .rst   (rst),
    .din   (supplyOk),
    .dout  (supplySync)
  );
  sync_two uSyncWake (
    .clock (clock),
    .rst   (rst),
    .din   (wakeReq),
    .dout  (wakeSync)
  );

  // wake edge detect on the synchronised level
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wakeSeen_reg <= 1'b0;
    end else begin
      wakeSeen_reg <= wakeSync;
    end
  end
  logic wakeRise;
  assign wakeRise = wakeSync & ~wakeSeen_reg;

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  logic [1:0] startSel_reg;
  logic       rstDis_reg;
  logic [3:0] ckSrc_reg;
  clock_startup_pkg::trim_t trim_reg;

  logic wrTrim;
  logic wrCfg;
  assign wrTrim = regWrite && regAddr == `ADDR_TRIM;
  assign wrCfg  = regWrite && regAddr == `ADDR_CONFIG;

  // trim: factory value at reset, software any time after
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      trim_reg <= `FACTORY_TRIM;
    end else if (wrTrim) begin
      trim_reg <= regWdata;
    end
  end

  // configuration stands in for the fuse settings
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      startSel_reg <= `STARTSEL_RESET;
      rstDis_reg   <= 1'b0;
      ckSrc_reg    <= `CKSRC_RESET;
    end else if (wrCfg) begin
      startSel_reg <= regWdata[`CFG_STARTSEL_HI:`CFG_STARTSEL_LO];
      rstDis_reg   <= regWdata[`CFG_RSTDIS_BIT];
      ckSrc_reg    <= regWdata[`CFG_CKSRC_HI:`CFG_CKSRC_LO];
    end
  end

  logic isLowPwr;
  assign isLowPwr = (ckSrc_reg == `CKSRC_LOWPWR);

  // -----------------------------------------------------------------
  // delay selection
  // -----------------------------------------------------------------
  localparam logic [15:0] US_RC_SHORT = 16'(`DLY_RC_SHORT_US);
  localparam logic [15:0] US_RC_LONG  = 16'(`DLY_RC_LONG_US);
  localparam logic [15:0] US_LP_SHORT = 16'(`DLY_LP_SHORT_US);
  localparam logic [15:0] US_LP_LONG  = 16'(`DLY_LP_LONG_US);
  localparam logic [15:0] US_RSTDIS   = 16'(`DLY_RSTDIS_US);
  localparam logic [7:0]  TICK_LOAD   = 8'(`US_TICKS - 1);

  logic [15:0] usNeeded;
  logic        startSelRsvd;

  // reserved code 11 is treated as the longest option, the safe side
  always_comb begin
    startSelRsvd = (startSel_reg == 2'h3);
    case (startSel_reg)
      2'h0: usNeeded = rstDis_reg ? US_RSTDIS : 16'h0000;
      2'h1: usNeeded = isLowPwr ? US_LP_SHORT : US_RC_SHORT;
      2'h2: usNeeded = isLowPwr ? US_LP_LONG : US_RC_LONG;
      default: usNeeded = isLowPwr ? US_LP_LONG : US_RC_LONG;
    endcase
  end

  // -----------------------------------------------------------------
  // sequencer
  // -----------------------------------------------------------------
  clock_startup_pkg::seq_state_t state_reg;
  clock_startup_pkg::seq_state_t state_next;
  logic        cycLoad;
  logic [15:0] cycStart;
  logic        cycZero;
  logic        usLoad;
  logic        usZero;
  logic [7:0]  tick_reg;
  logic        tickPulse;
  logic        fromReset_reg;

  // cycle counter for the 14- or 6-cycle part
  down_counter #(.W(16)) uCyc (
    .clock    (clock),
    .rst      (rst),
    .load     (cycLoad),
    .startVal (cycStart),
    .count    (state_reg == clock_startup_pkg::SEQ_CYC),
    .zero     (cycZero)
  );

  // microsecond counter for the millisecond part
  down_counter #(.W(16)) uUs (
    .clock    (clock),
    .rst      (rst),
    .load     (usLoad),
    .startVal (usNeeded),
    .count    (tickPulse && state_reg == clock_startup_pkg::SEQ_MS),
    .zero     (usZero)
  );

  // fixed 1 us reference, independent of the core clock choice
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tick_reg <= TICK_LOAD;
    end else if (state_reg != clock_startup_pkg::SEQ_MS || tick_reg == 8'h00) begin
      tick_reg <= TICK_LOAD;
    end else begin
      tick_reg <= tick_reg - 8'h01;
    end
  end
  assign tickPulse = (tick_reg == 8'h00);

  // next state and counter loads
  always_comb begin
    state_next = state_reg;
    cycLoad    = 1'b0;
    cycStart   = `RESET_CK;
    usLoad     = 1'b0;
    case (state_reg)
      clock_startup_pkg::SEQ_HOLD: begin
        if (supplySync) begin
          state_next = clock_startup_pkg::SEQ_CYC;
          cycLoad    = 1'b1;
          cycStart   = `RESET_CK;
          usLoad     = 1'b1;
        end
      end
      clock_startup_pkg::SEQ_CYC: begin
        if (cycZero) begin
          state_next = (fromReset_reg && !usZero) ? clock_startup_pkg::SEQ_MS
                                                  : clock_startup_pkg::SEQ_RUN;
        end
      end
      clock_startup_pkg::SEQ_MS: begin
        if (usZero) begin
          state_next = clock_startup_pkg::SEQ_RUN;
        end
      end
      clock_startup_pkg::SEQ_RUN: begin
        if (wakeRise) begin
          state_next = clock_startup_pkg::SEQ_CYC;
          cycLoad    = 1'b1;
          cycStart   = `WAKE_CK;
        end
      end
      default: state_next = clock_startup_pkg::SEQ_HOLD;
    endcase
    if (!supplySync) begin
      state_next = clock_startup_pkg::SEQ_HOLD;
      cycLoad    = 1'b0;
      usLoad     = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= clock_startup_pkg::SEQ_HOLD;
    end else begin
      state_reg <= state_next;
    end
  end

  // wake skips the millisecond part
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fromReset_reg <= 1'b1;
    end else if (state_reg == clock_startup_pkg::SEQ_HOLD) begin
      fromReset_reg <= 1'b1;
    end else if (state_reg == clock_startup_pkg::SEQ_RUN && wakeRise) begin
      fromReset_reg <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // outputs, all registered
  // -----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      coreHold       <= 1'b1;
      trimValue      <= `FACTORY_TRIM;
      rangeSelectBit <= 1'b1;
      fineTuneBits   <= 7'h00;
      lowPowerClk    <= 1'b0;
    end else begin
      coreHold       <= (state_next != clock_startup_pkg::SEQ_RUN);
      trimValue      <= trim_reg;
      rangeSelectBit <= trim_reg[`TRIM_RANGE_BIT];
      fineTuneBits   <= trim_reg[6:0];
      lowPowerClk    <= isLowPwr;
    end
  end

  // read data in the cycle after the strobe, zero otherwise
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      regRdata <= `READ_ZERO;
    end else if (regRead) begin
      case (regAddr)
        `ADDR_TRIM:    regRdata <= trim_reg;
        `ADDR_CONFIG:  regRdata <= {ckSrc_reg, 1'b0, rstDis_reg, startSel_reg};
        `ADDR_STATUS:  regRdata <= {5'h00, isLowPwr, startSelRsvd, coreHold};
        `ADDR_FACTORY: regRdata <= `FACTORY_TRIM;
        default:       regRdata <= `READ_ZERO;
      endcase
    end else begin
      regRdata <= `READ_ZERO;
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  sequence s_wakeStart;
    state_reg == clock_startup_pkg::SEQ_RUN && wakeRise && supplySync;
  endsequence

  a_trim_follows: assert property (@(posedge clock) disable iff (rst)
    wrTrim |=> ##1 trimValue == $past(regWdata, 2))
    else $error("trim output did not follow write");

  // tied to the written byte, not to another output, so a swapped field shows
  a_range_bit: assert property (@(posedge clock) disable iff (rst)
    wrTrim |=> ##1 {rangeSelectBit, 7'h00} == ($past(regWdata, 2) & 8'h80))
    else $error("range bit mismatch");

  a_fine_bits: assert property (@(posedge clock) disable iff (rst)
    wrTrim |=> ##1 {1'h0, fineTuneBits} == ($past(regWdata, 2) & 8'h7F))
    else $error("fine tune bits mismatch");

  a_lowpwr_sel: assert property (@(posedge clock) disable iff (rst)
    (wrCfg && regWdata[7:4] == 4'h3) |=> ##1 lowPowerClk)
    else $error("low power clock not selected");

  a_hold_supply: assert property (@(posedge clock) disable iff (rst)
    !supplySync |=> coreHold)
    else $error("core released without supply");

  a_wake_delay: assert property (@(posedge clock) disable iff (rst)
    s_wakeStart ##1 supplySync [*6] |=> coreHold ##1 !coreHold)
    else $error("wake delay not six cycles");

  a_reset_select: assert property (@(posedge clock)
    $fell(rst) |-> startSel_reg == `STARTSEL_RESET)
    else $error("start-up select not at default");

  a_factory_load: assert property (@(posedge clock)
    $fell(rst) |-> trim_reg == `FACTORY_TRIM)
    else $error("factory trim not loaded");

  // checked at the load, since software may rewrite the select during a delay
  a_rstdis_delay: assert property (@(posedge clock) disable iff (rst)
    (usLoad && startSel_reg == 2'h0) |=> (usZero != $past(rstDis_reg)))
    else $error("reset pin disable delay not applied");

endmodule // clock_startup_calibration
`default_nettype wire

// ---- include/clock_startup_consts.svh ----
// constants for the clock start-up and trim block
// assumes a 50 MHz block clock; millisecond delays kept in microseconds
`ifndef CLOCK_STARTUP_CONSTS_SVH
`define CLOCK_STARTUP_CONSTS_SVH

// -----------------------------------------------------------------
// register offsets (plain port address)
// -----------------------------------------------------------------
`define ADDR_TRIM        4'h0
`define ADDR_CONFIG      4'h1
`define ADDR_STATUS      4'h2
`define ADDR_FACTORY     4'h3

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define CFG_STARTSEL_LO  0
`define CFG_STARTSEL_HI  1
`define CFG_RSTDIS_BIT   2
`define CFG_CKSRC_LO     4
`define CFG_CKSRC_HI     7
`define TRIM_RANGE_BIT   7
`define STAT_HOLD_BIT    0
`define STAT_RSVD_BIT    1
`define STAT_LOWPWR_BIT  2

// -----------------------------------------------------------------
// reset values and codes
// -----------------------------------------------------------------
`define STARTSEL_RESET   2'h2
`define CKSRC_RESET      4'h2
`define CKSRC_LOWPWR     4'h3
`define FACTORY_TRIM     8'h80
`define READ_ZERO        8'h00

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define CLK_MHZ          50
`define WAKE_CK          16'h0006
`define RESET_CK         16'h000E
`define DLY_RC_SHORT_US  4100
`define DLY_RC_LONG_US   65000
`define DLY_LP_SHORT_US  4000
`define DLY_LP_LONG_US   64000
`define DLY_RSTDIS_US    4100
`define US_TICKS         (`CLK_MHZ)

`endif

// ---- include/clock_startup_pkg.sv ----
// types for the clock start-up and trim block
// assumes the constants header is compiled alongside
package clock_startup_pkg;
  typedef enum logic [1:0] {
    SEQ_HOLD  = 2'b00,
    SEQ_CYC   = 2'b01,
    SEQ_MS    = 2'b10,
    SEQ_RUN   = 2'b11
  } seq_state_t;
  typedef logic [7:0] trim_t;
endpackage

// ---- src/down_counter.sv ----
// loadable down counter with a done pulse-free level
// assumes load and count are from the block clock domain
`timescale 1ns/1ps
`default_nettype none
module down_counter #(
  parameter int W = 16
) (
  input  wire logic         clock,    // block clock
  input  wire logic         rst,      // async reset, high
  input  wire logic         load,     // load start value
  input  wire logic [W-1:0] startVal, // value to load
  input  wire logic         count,    // decrement enable
  output logic              zero      // count has reached zero
);
  logic [W-1:0] cnt_reg;

  // load wins over count so a restart is never missed
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (load) begin
      cnt_reg <= startVal;
    end else if (count && cnt_reg != '0) begin
      cnt_reg <= cnt_reg - W'(1);
    end
  end

  assign zero = (cnt_reg == '0);
endmodule // down_counter
`default_nettype wire

// ---- src/sync_two.sv ----
// two-stage synchroniser for one level
// assumes input is asynchronous to clock
`timescale 1ns/1ps
`default_nettype none
module sync_two (
  input  wire logic clock,  // block clock
  input  wire logic rst,    // async reset, high
  input  wire logic din,    // asynchronous level
  output logic      dout    // synchronised level
);
  logic meta_reg;

  // first stage feeds only the second
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_reg <= 1'b0;
      dout     <= 1'b0;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule // sync_two
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the clock start-up and trim block
// assumes the constants header is on the include path; the bench drives every port
`timescale 1ns/1ps
`default_nettype none
`include "clock_startup_consts.svh"
// one compare: counts it, reports a mismatch at once
`define CHK(what, exp, got) begin cmpCount++; if ((got) !== (exp)) begin errCount++; \
  $display("unexpected %s expected %h seen %h", what, exp, got); end end
module testbench;
  logic       clock;
  logic       rst;
  logic [3:0] regAddr;
  logic [7:0] regWdata;
  logic       regWrite;
  logic       regRead;
  logic [7:0] regRdata;
  logic       supplyOk;
  logic       wakeReq;
  logic       coreHold;
  logic [7:0] trimValue;
  logic       rangeSelectBit;
  logic [6:0] fineTuneBits;
  logic       lowPowerClk;
  int         errCount;
  int         cmpCount;
  int         n;
  int         m;
  logic [7:0] d;
  logic [7:0] trimTab [4] = '{8'h7F, 8'h80, 8'h00, 8'hFF};
  logic [7:0] cfgTab [9] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h30, 8'h31, 8'h32, 8'h34};
  logic       shortTab [9] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};

  clock_startup_calibration dut (
    .clock          (clock),
    .rst            (rst),
    .regAddr        (regAddr),
    .regWdata       (regWdata),
    .regWrite       (regWrite),
    .regRead        (regRead),
    .regRdata       (regRdata),
    .supplyOk       (supplyOk),
    .wakeReq        (wakeReq),
    .coreHold       (coreHold),
    .trimValue      (trimValue),
    .rangeSelectBit (rangeSelectBit),
    .fineTuneBits   (fineTuneBits),
    .lowPowerClk    (lowPowerClk)
  );

  // -------------------------------------------------------------
  // clock and hang guard
  // -------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // a hung wait would otherwise never reach the verdict
  initial begin
    repeat (60000) @(posedge clock);
    errCount++;
    close_out();
  end

  // -------------------------------------------------------------
  // bus tasks and verdict
  // -------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock);
    regAddr  <= a;
    regWdata <= v;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    v = regRdata;
  endtask
  // counts edges until the core is let go, bounded
  task automatic wait_release(input int limit, output int cnt);
    cnt = 0;
    while (coreHold !== 1'b0 && cnt < limit) begin
      @(posedge clock);
      #1;
      cnt++;
    end
    if (cnt >= limit) begin
      errCount++;
      $display("unexpected release wait expected %0d seen %0d", limit, cnt);
      close_out();
    end
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    errCount = 0;
    cmpCount = 0;
    rst = 1'b1;
    regAddr = 4'h0;
    regWdata = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    supplyOk = 1'b0;
    wakeReq = 1'b0;
    repeat (4) @(posedge clock);
    #1;
    `CHK("trim at reset", `FACTORY_TRIM, trimValue)
    `CHK("range at reset", `FACTORY_TRIM >> 7, rangeSelectBit)
    `CHK("hold at reset", 1'b1, coreHold)
    @(posedge clock);
    rst <= 1'b0;
    // register reset values, read-only and unmapped places
    rd(`ADDR_TRIM, d);
    `CHK("trim reg", `FACTORY_TRIM, d)
    @(posedge clock);
    #1;
    `CHK("read data after", 8'h00, regRdata)
    rd(`ADDR_CONFIG, d);
    `CHK("config reset", {`CKSRC_RESET, 2'h0, `STARTSEL_RESET}, d)
    wr(`ADDR_FACTORY, 8'h11);
    rd(`ADDR_FACTORY, d);
    `CHK("factory ro", `FACTORY_TRIM, d)
    wr(4'hF, 8'h5A);
    rd(4'hF, d);
    `CHK("unmapped", 8'h00, d)
    // trim writes reach the oscillator pins one cycle later
    // no nonvolatile write runs here, so every trim code is safe to apply
    for (int i = 0; i < 4; i++) begin
      wr(`ADDR_TRIM, trimTab[i]);
      @(posedge clock);
      #1;
      `CHK("trim pins", trimTab[i], trimValue)
      `CHK("range bit", trimTab[i][7], rangeSelectBit)
      `CHK("tune bits", trimTab[i][6:0], fineTuneBits)
      rd(`ADDR_TRIM, d);
      `CHK("trim readback", trimTab[i], d)
    end
    // start-up delay for each select code on the RC source and codes 00 to 10 on the 128 kHz source
    for (int i = 0; i < 9; i++) begin
      wr(`ADDR_CONFIG, cfgTab[i]);
      @(posedge clock);
      #1;
      `CHK("low power src", cfgTab[i][7:4] == `CKSRC_LOWPWR, lowPowerClk)
      @(posedge clock);
      supplyOk <= 1'b1;
      if (shortTab[i]) begin
        wait_release(60, n);
        `CHK("release window", 1'b1, (n >= 16 && n <= 22))
        rd(`ADDR_STATUS, d);
        `CHK("status", {5'h00, cfgTab[i][7:4] == `CKSRC_LOWPWR, 2'h0}, d)
        // wake is a short cycle-only hold
        @(posedge clock);
        wakeReq <= 1'b1;
        n = 0;
        while (coreHold !== 1'b1 && n < 8) begin
          @(posedge clock);
          #1;
          n++;
        end
        m = 0;
        while (coreHold === 1'b1 && m < 20) begin
          @(posedge clock);
          #1;
          m++;
        end
        `CHK("wake hold", 1'b1, (m >= 6 && m <= 8))
        @(posedge clock);
        wakeReq <= 1'b0;
      end else begin
        // the millisecond part keeps the core held far past the cycle part
        repeat (1000) @(posedge clock);
        #1;
        `CHK("long hold", 1'b1, coreHold)
        rd(`ADDR_STATUS, d);
        `CHK("status hold", 1'h1, d[0])
        `CHK("status rsvd", cfgTab[i][1:0] == 2'h3, d[1])
      end
      @(posedge clock);
      supplyOk <= 1'b0;
      repeat (4) @(posedge clock);
      #1;
      `CHK("supply drop", 1'b1, coreHold)
    end
    // second chip reset in mid-run reloads the factory trim
    wr(`ADDR_TRIM, 8'h3C);
    @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    #1;
    `CHK("trim reload", `FACTORY_TRIM, trimValue)
    @(posedge clock);
    rst <= 1'b0;
    rd(`ADDR_TRIM, d);
    `CHK("trim reg reload", `FACTORY_TRIM, d)
    rd(`ADDR_CONFIG, d);
    `CHK("config reload", {`CKSRC_RESET, 2'h0, `STARTSEL_RESET}, d)
    close_out();
  end
endmodule // testbench
`default_nettype wire
